/* common/ibf_pkg.sv */
// Constants, field layouts and carrier types of the instruction buffer fetch block
package ibf_pkg;
   // Storage geometry
   localparam int NBUF = 8;                      // Instruction buffers
   localparam int BUF_WORDS = 32;                // Words per buffer
   localparam int WORD_W = 16;                   // Bits per stored word
   localparam int PA_W = 30;                     // Program word address width
   localparam int OFF_W = 5;                     // Element offset inside a buffer
   localparam int BLK_W = 25;                    // Block address, upper program address bits
   localparam int BUF_W = 3;                     // Buffer select width
   localparam int SLICES = 4;                    // Byte-wide storage slices

   // Positions inside a buffer
   localparam logic [4:0] PF_POS = 5'h18;        // Prefetch trigger, octal 30
   localparam logic [4:0] LAST_POS = 5'h1f;      // Last element, octal 37
   localparam logic [4:0] DS_WORDS = 5'h10;      // Exchange package size, octal 20
   localparam logic [2:0] BYP_N = 3'h4;          // Words that take the bypass path
   localparam logic [5:0] REQ_N = 6'h20;         // Requests per block fetch

   // Register map, byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_LIMIT = 8'h08;
   localparam logic [7:0] REG_PTR = 8'h0c;
   localparam logic CTRL_EN_RST = 1'b1;          // Issue enabled after reset
   localparam logic [29:0] LIMIT_RST = 30'h3fffffff;

   // Status bit positions
   localparam int ST_FBUSY = 0;
   localparam int ST_WAIT = 1;
   localparam int ST_BYP = 2;
   localparam int ST_DSDONE = 3;
   localparam int ST_CODEERR = 4;
   localparam int ST_RANGEERR = 5;
   localparam int ST_PFPEND = 6;
   localparam int ST_MISSPEND = 7;

   // Return code sent with every memory word: valid, buffer, element
   typedef struct packed {
      logic vld;
      logic [2:0] buf_sel;
      logic [4:0] elem;
   } ibf_tag_t;

   // One returned word with its code
   typedef struct packed {
      ibf_tag_t tag;
      logic [15:0] data;
   } ibf_ret_t;

   // One word fetch request toward common memory
   typedef struct packed {
      logic vld;
      logic [29:0] addr;
      ibf_tag_t tag;
      logic [1:0] grp;
   } ibf_req_t;

   // One word handed to the issue controller
   typedef struct packed {
      logic vld;
      logic [15:0] word;
      logic [29:0] pa;
   } ibf_iss_t;

   // Fetch sequencer states
   typedef enum logic [0:0] {
      FE_IDLE,
      FE_REQ
   } ibf_fe_t;
endpackage : ibf_pkg

/* hw/ibf_buf_slot.sv */
// Per-buffer block address, fill map and valid bit
`timescale 1ns/10ps
module ibf_buf_slot #(
   parameter int BLK_W = 25,
   parameter int WORDS = 32
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic alloc_i,
   input wire logic [BLK_W-1:0] tag_i,
   input wire logic wr0_i,
   input wire logic [$clog2(WORDS)-1:0] el0_i,
   input wire logic wr1_i,
   input wire logic [$clog2(WORDS)-1:0] el1_i,
   output logic [BLK_W-1:0] tag_o,
   output logic live_o,
   output logic full_o,
   output logic first_o
);
   logic [WORDS-1:0] have_q;   // Element arrived map
   logic [BLK_W-1:0] tag_q;    // Block address register
   logic live_q;               // Allocated to a block

   // Allocation clears the map; arriving words fill it in any order
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         have_q <= '0;
         tag_q <= '0;
         live_q <= 1'b0;
      end else if (alloc_i) begin
         have_q <= '0;
         tag_q <= tag_i;
         live_q <= 1'b1;
      end else begin
         if (wr0_i) begin
            have_q[el0_i] <= 1'b1;
         end
         if (wr1_i) begin
            have_q[el1_i] <= 1'b1;
         end
      end
   end

   assign tag_o = tag_q;
   assign live_o = live_q;
   assign full_o = live_q && (&have_q);   // Buffer valid bit
   assign first_o = live_q && have_q[0];  // First word present
endmodule : ibf_buf_slot

/* hw/ibf_fetch_ctrl.sv */
// Instruction buffer store with fill, bypass, prefetch and issue control
`timescale 1ns/10ps
module ibf_fetch_ctrl (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire ibf_pkg::ibf_ret_t [1:0] ret_i,
   input wire logic req_rdy_i,
   output ibf_pkg::ibf_req_t req_o,
   input wire logic br_vld_i,
   input wire logic [29:0] br_addr_i,
   input wire logic iss_take_i,
   output ibf_pkg::ibf_iss_t iss_o,
   output logic ds_fetch_o,
   output logic [7:0] fanout_o
);
   import ibf_pkg::*;

   // Word storage, flip-flops indexed by buffer and element
   logic [WORD_W-1:0] mem_q [NBUF][BUF_WORDS];
   // Slot views
   logic [BLK_W-1:0] stag [NBUF];
   logic [NBUF-1:0] slive;
   logic [NBUF-1:0] sfull;
   logic [NBUF-1:0] sfirst;
   logic [NBUF-1:0] salloc;
   logic [NBUF-1:0] swr0;
   logic [NBUF-1:0] swr1;
   // Software visible control and status
   logic ctrl_en_q;            // Issue enable
   logic [PA_W-1:0] limit_q;   // Last valid translated word address
   logic code_err_q;           // Unexpected return code seen
   logic range_err_q;          // Prefetch beyond translated range
   logic [4:0] ds_cnt_q;       // Valid codes counted during deadstart
   logic ds_done_q;
   logic ds_fetch_q;
   // Issue side
   logic [BUF_W-1:0] cur_q;    // Buffer being read
   logic [OFF_W-1:0] ptr_q;    // Read-out pointer
   logic byp_q;                // Bypass mode
   logic [OFF_W-1:0] need_q;   // First needed element
   logic [2:0] wp_q;           // Bypass write pointer
   logic [2:0] rp_q;           // Bypass read pointer
   logic [WORD_W-1:0] byp_dat_q [4];
   logic wait_first_q;         // Waiting for the first word of a new buffer
   logic miss_q;               // Target fetch pending
   logic [PA_W-1:0] miss_addr_q;
   logic pf_q;                 // Prefetch pending
   logic [BLK_W-1:0] pf_blk_q;
   ibf_iss_t iss_q;
   // Fetch side
   ibf_fe_t fe_q;
   logic [BLK_W-1:0] fe_blk_q;
   logic [OFF_W-1:0] fe_start_q;
   logic [5:0] fe_cnt_q;
   logic [BUF_W-1:0] fe_buf_q;
   logic [BUF_W-1:0] rr_q;     // Round-robin replacement pointer
   ibf_req_t req_q;
   logic [7:0] fan_q;
   // Bus slave
   logic wb_ack_q;
   logic [31:0] wb_dat_q;

   // Combinational terms
   logic [1:0] lane_ok;
   logic [3:0] br_look;
   logic [3:0] pf_look;
   logic [3:0] nx_look;
   logic [BLK_W-1:0] nx_blk;
   logic pf_over;
   logic pf_drop;
   logic go_br;
   logic go_pf;
   logic [BUF_W-1:0] victim;
   logic m0;
   logic m1;
   logic [OFF_W-1:0] exp0;
   logic [OFF_W-1:0] exp1;
   logic [WORD_W-1:0] rd_word;
   logic byp_ok;
   logic buf_ok;
   logic load;
   logic bus_req;
   logic [31:0] stat_w;

   // Lookup of a block among the slots; ok selects live or valid slots
   function automatic logic [3:0] find_blk(input logic [BLK_W-1:0] b,
                                          input logic [NBUF-1:0] ok);
      logic [3:0] r;
      r = '0;
      for (int i = NBUF - 1; i >= 0; i--) begin
         if (ok[i] && stag[i] == b) begin
            r = {1'b1, 3'(i)};
         end
      end
      return r;
   endfunction : find_blk

   // One slot per buffer holds block address and fill state
   for (genvar g = 0; g < NBUF; g++) begin : g_slot
      ibf_buf_slot #(
         .BLK_W(BLK_W),
         .WORDS(BUF_WORDS)
      ) u_slot (
         .ref_clk_i(ref_clk_i),
         .rst_i(rst_i),
         .alloc_i(salloc[g]),
         .tag_i(go_br ? miss_addr_q[PA_W-1:OFF_W] : pf_blk_q),
         .wr0_i(swr0[g]),
         .el0_i(ret_i[0].tag.elem),
         .wr1_i(swr1[g]),
         .el1_i(ret_i[1].tag.elem),
         .tag_o(stag[g]),
         .live_o(slive[g]),
         .full_o(sfull[g]),
         .first_o(sfirst[g])
      );
      assign salloc[g] = (go_br || go_pf) && victim == 3'(g);
      assign swr0[g] = lane_ok[0] && ret_i[0].tag.buf_sel == 3'(g);
      assign swr1[g] = lane_ok[1] && ret_i[1].tag.buf_sel == 3'(g);
   end

   // Incoming code is accepted only for a buffer still being filled
   always_comb begin
      for (int k = 0; k < 2; k++) begin
         lane_ok[k] = ret_i[k].tag.vld && slive[ret_i[k].tag.buf_sel] &&
                      !sfull[ret_i[k].tag.buf_sel];
      end
   end

   // Residency: branch checks valid buffers, sequential checks allocated ones
   // A process, not assigns: slot tags read inside the function must retrigger it
   always_comb begin
      br_look = find_blk(br_addr_i[PA_W-1:OFF_W], sfull);
      pf_look = find_blk(pf_blk_q, slive);
      nx_look = find_blk(nx_blk, slive);
   end
   assign nx_blk = stag[cur_q] + 25'h1;
   assign pf_over = {pf_blk_q, 5'h00} > limit_q;
   assign pf_drop = pf_q && (pf_look[3] || pf_over);

   // Fetch starts; a pending target always wins over a prefetch
   assign go_br = fe_q == FE_IDLE && miss_q && !br_vld_i;
   assign go_pf = fe_q == FE_IDLE && pf_q && !pf_drop && !miss_q && !br_vld_i;
   // A prefetch never evicts the buffer being read
   assign victim = (rr_q == cur_q && !go_br) ? rr_q + 3'h1 : rr_q;

   // Bypass capture of the needed words in arrival order
   assign exp0 = need_q + 5'(wp_q);
   assign m0 = byp_q && wp_q < BYP_N && lane_ok[0] && ret_i[0].tag.buf_sel == cur_q &&
               ret_i[0].tag.elem == exp0;
   assign exp1 = exp0 + {4'h0, m0};
   assign m1 = byp_q && (wp_q + {2'h0, m0}) < BYP_N && lane_ok[1] &&
               ret_i[1].tag.buf_sel == cur_q && ret_i[1].tag.elem == exp1;

   // Even and odd words leave the store together; pointer bit 0 picks one
   always_comb begin
      logic [2 * WORD_W-1:0] pair;
      pair = {mem_q[cur_q][{ptr_q[4:1], 1'b1}], mem_q[cur_q][{ptr_q[4:1], 1'b0}]};
      rd_word = ptr_q[0] ? pair[2 * WORD_W-1:WORD_W] : pair[WORD_W-1:0];
   end

   // Issue sources: bypass while write leads read, else a valid buffer
   assign byp_ok = byp_q && rp_q < wp_q;
   assign buf_ok = !byp_q && sfull[cur_q] && !wait_first_q;
   assign load = ctrl_en_q && !miss_q && (!iss_q.vld || iss_take_i) && (byp_ok || buf_ok);

   // Storage writes: the code alone decides the position
   always_ff @(posedge ref_clk_i) begin
      for (int k = 0; k < 2; k++) begin
         if (lane_ok[k]) begin
            mem_q[ret_i[k].tag.buf_sel][ret_i[k].tag.elem] <= ret_i[k].data;
         end
      end
   end

   // Deadstart: count valid codes until the exchange package is in
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ds_cnt_q <= '0;
         ds_done_q <= 1'b0;
         ds_fetch_q <= 1'b0;
      end else begin
         ds_fetch_q <= 1'b0;
         if (!ds_done_q) begin
            // Two lanes may both carry a code in one transfer
            if (6'(ds_cnt_q) + 6'(ret_i[0].tag.vld) + 6'(ret_i[1].tag.vld) >= 6'(DS_WORDS)) begin
               ds_done_q <= 1'b1;
               ds_fetch_q <= 1'b1;
            end else begin
               ds_cnt_q <= ds_cnt_q + 5'(ret_i[0].tag.vld) + 5'(ret_i[1].tag.vld);
            end
         end
      end
   end

   // Issue, bypass, branch and prefetch bookkeeping
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cur_q <= '0;
         ptr_q <= '0;
         byp_q <= 1'b0;
         need_q <= '0;
         wp_q <= '0;
         rp_q <= '0;
         wait_first_q <= 1'b0;
         miss_q <= 1'b0;
         miss_addr_q <= '0;
         pf_q <= 1'b0;
         pf_blk_q <= '0;
         iss_q <= '0;
         for (int i = 0; i < 4; i++) begin
            byp_dat_q[i] <= '0;
         end
      end else begin
         // Word handed over
         if (iss_q.vld && iss_take_i) begin
            iss_q.vld <= 1'b0;
         end
         // Bypass write side
         if (m0) begin
            byp_dat_q[wp_q[1:0]] <= ret_i[0].data;
         end
         if (m1) begin
            byp_dat_q[2'(wp_q + {2'h0, m0})] <= ret_i[1].data;
         end
         wp_q <= wp_q + {2'h0, m0} + {2'h0, m1};
         // Bypass done and buffer valid: issue moves to the buffer
         if (byp_q && rp_q == BYP_N && sfull[cur_q]) begin
            byp_q <= 1'b0;
         end
         if (wait_first_q && sfirst[cur_q]) begin
            wait_first_q <= 1'b0;
         end
         // Prefetch resolved as resident or out of range, or started
         if (pf_drop || go_pf) begin
            pf_q <= 1'b0;
         end
         if (br_vld_i) begin
            // Branch: any queued word is stale
            iss_q.vld <= 1'b0;
            wait_first_q <= 1'b0;
            byp_q <= 1'b0;
            if (br_look[3]) begin
               cur_q <= br_look[2:0];
               ptr_q <= br_addr_i[OFF_W-1:0];
               pf_q <= br_addr_i[OFF_W-1:0] >= PF_POS;
               pf_blk_q <= br_addr_i[PA_W-1:OFF_W] + 25'h1;
            end else begin
               miss_q <= 1'b1;
               miss_addr_q <= br_addr_i;
               pf_q <= 1'b0;
            end
         end else if (go_br) begin
            // Target fetch begins; its first words go through bypass
            miss_q <= 1'b0;
            cur_q <= victim;
            ptr_q <= miss_addr_q[OFF_W-1:0];
            need_q <= miss_addr_q[OFF_W-1:0];
            byp_q <= 1'b1;
            wp_q <= '0;
            rp_q <= '0;
            pf_q <= miss_addr_q[OFF_W-1:0] >= PF_POS;
            pf_blk_q <= miss_addr_q[PA_W-1:OFF_W] + 25'h1;
         end else if (load) begin
            iss_q.vld <= 1'b1;
            iss_q.word <= byp_q ? byp_dat_q[rp_q[1:0]] : rd_word;
            iss_q.pa <= {stag[cur_q], ptr_q};
            ptr_q <= ptr_q + 5'h1;
            if (byp_q) begin
               rp_q <= rp_q + 3'h1;
            end else if (ptr_q == LAST_POS) begin
               // End of buffer: step to the next sequential block
               if (nx_look[3]) begin
                  cur_q <= nx_look[2:0];
                  wait_first_q <= !sfirst[nx_look[2:0]];
               end else begin
                  miss_q <= 1'b1;
                  miss_addr_q <= {nx_blk, 5'h00};
                  pf_q <= 1'b0;
               end
            end
            if (!byp_q && ptr_q == PF_POS) begin
               pf_q <= 1'b1;
               pf_blk_q <= nx_blk;
            end
         end
      end
   end

   // Fetch sequencer: 32 requests, needed word first, wrap inside the block
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fe_q <= FE_IDLE;
         fe_blk_q <= '0;
         fe_start_q <= '0;
         fe_cnt_q <= '0;
         fe_buf_q <= '0;
         rr_q <= '0;
         req_q <= '0;
      end else begin
         if (req_q.vld && req_rdy_i) begin
            req_q.vld <= 1'b0;
         end
         case (fe_q)
            FE_IDLE: begin
               if (go_br || go_pf) begin
                  fe_q <= FE_REQ;
                  fe_blk_q <= go_br ? miss_addr_q[PA_W-1:OFF_W] : pf_blk_q;
                  fe_start_q <= go_br ? miss_addr_q[OFF_W-1:0] : 5'h00;
                  fe_cnt_q <= '0;
                  fe_buf_q <= victim;
                  rr_q <= victim + 3'h1;
               end
            end
            FE_REQ: begin
               // A stalled request holds until memory takes it
               if (!req_q.vld || req_rdy_i) begin
                  if (fe_cnt_q == REQ_N) begin
                     fe_q <= FE_IDLE;
                  end else begin
                     req_q.vld <= 1'b1;
                     req_q.addr <= {fe_blk_q, fe_start_q + fe_cnt_q[4:0]};
                     req_q.tag.vld <= 1'b1;
                     req_q.tag.buf_sel <= fe_buf_q;
                     req_q.tag.elem <= fe_start_q + fe_cnt_q[4:0];
                     req_q.grp <= fe_cnt_q[4:3];
                     fe_cnt_q <= fe_cnt_q + 6'h01;
                  end
               end
            end
            default: begin
               fe_q <= FE_IDLE;
            end
         endcase
      end
   end

   // Destination code fan-out: each byte slice receives two bits
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fan_q <= '0;
      end else begin
         for (int s = 0; s < SLICES; s++) begin
            fan_q[2 * s +: 2] <= (fe_q == FE_REQ) ?
                                 {fe_buf_q == 3'(2 * s + 1), fe_buf_q == 3'(2 * s)} : 2'h0;
         end
      end
   end

   // Sticky errors; a new event in the clearing cycle wins
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         code_err_q <= 1'b0;
         range_err_q <= 1'b0;
      end else begin
         if (bus_req && wb_we_i && wb_adr_i == REG_STAT && wb_sel_i[0]) begin
            if (wb_dat_i[ST_CODEERR]) code_err_q <= 1'b0;
            if (wb_dat_i[ST_RANGEERR]) range_err_q <= 1'b0;
         end
         if ((ret_i[0].tag.vld && !lane_ok[0]) || (ret_i[1].tag.vld && !lane_ok[1])) begin
            code_err_q <= 1'b1;
         end
         if (pf_q && !pf_look[3] && pf_over) begin
            range_err_q <= 1'b1;
         end
      end
   end

   // Wishbone slave: answer one cycle after the request, one-cycle ack
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_q;
   assign stat_w = {24'h0, miss_q, pf_q, range_err_q, code_err_q, ds_done_q, byp_q,
                    wait_first_q, fe_q == FE_REQ};
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wb_ack_q <= 1'b0;
         wb_dat_q <= '0;
         ctrl_en_q <= CTRL_EN_RST;
         limit_q <= LIMIT_RST;
      end else begin
         wb_ack_q <= bus_req;
         if (bus_req) begin
            case (wb_adr_i)
               REG_CTRL: wb_dat_q <= {31'h0, ctrl_en_q};
               REG_STAT: wb_dat_q <= stat_w;
               REG_LIMIT: wb_dat_q <= {2'h0, limit_q};
               REG_PTR: wb_dat_q <= {2'h0, stag[cur_q], ptr_q};
               default: wb_dat_q <= '0;   // Unmapped reads as zero
            endcase
            if (wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
               ctrl_en_q <= wb_dat_i[0];
            end
            if (wb_we_i && wb_adr_i == REG_LIMIT) begin
               if (wb_sel_i[0]) limit_q[7:0] <= wb_dat_i[7:0];
               if (wb_sel_i[1]) limit_q[15:8] <= wb_dat_i[15:8];
               if (wb_sel_i[2]) limit_q[23:16] <= wb_dat_i[23:16];
               if (wb_sel_i[3]) limit_q[29:24] <= wb_dat_i[29:24];
            end
         end
      end
   end

   assign wb_ack_o = wb_ack_q;
   assign wb_dat_o = wb_dat_q;
   assign req_o = req_q;
   assign iss_o = iss_q;
   assign ds_fetch_o = ds_fetch_q;
   assign fanout_o = fan_q;
endmodule : ibf_fetch_ctrl

/* tb/ibf_chk_sva.sv */
// Port assertions for the instruction buffer fetch block
`timescale 1ns/10ps
module ibf_chk (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic req_rdy_i,
   input wire ibf_pkg::ibf_req_t req_o,
   input wire ibf_pkg::ibf_ret_t [1:0] ret_i,
   input wire logic br_vld_i,
   input wire logic iss_take_i,
   input wire ibf_pkg::ibf_iss_t iss_o,
   input wire logic ds_fetch_o,
   input wire logic [7:0] fanout_o
);
   import ibf_pkg::*;
   logic [5:0] codes_q; // Valid codes seen, saturating
   logic ds_seen_q; // Deadstart already pulsed
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // Saturation keeps the count from wrapping back under the trigger figure
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         codes_q <= 6'h00;
         ds_seen_q <= 1'b0;
      end else begin
         if (codes_q < 6'h20) begin
            codes_q <= codes_q + 6'(ret_i[0].tag.vld) + 6'(ret_i[1].tag.vld);
         end
         ds_seen_q <= ds_seen_q | ds_fetch_o;
      end
   end
   ack_one_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   ack_turn_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   req_hold_a: assert property (req_o.vld && !req_rdy_i |=> $stable(req_o))
      else $error("request changed while waiting");
   req_order_a: assert property (req_o.vld && req_rdy_i |=>
      !req_o.vld || req_o.tag.elem == $past(req_o.tag.elem) + 5'h01) else $error("bad order");
   req_addr_a: assert property (req_o.vld |->
      req_o.tag.vld && req_o.addr[4:0] == req_o.tag.elem) else $error("tag and address differ");
   fan_buf_a: assert property (req_o.vld |-> fanout_o == 8'h01 << req_o.tag.buf_sel)
      else $error("fanout wrong");
   iss_hold_a: assert property (iss_o.vld && !iss_take_i && !br_vld_i |=> $stable(iss_o))
      else $error("issue word dropped");
   ds_count_a: assert property (ds_fetch_o |-> codes_q >= 6'h10) else $error("deadstart early");
   ds_once_a: assert property (ds_fetch_o |-> !ds_seen_q) else $error("deadstart twice");
endmodule : ibf_chk

/* tb/ibf_mem_model.sv */
// Common memory model: takes word requests, returns tagged words two at a time
`timescale 1ns/10ps
module ibf_mem_model (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire ibf_pkg::ibf_req_t req_o,
   output logic req_rdy_o,
   output ibf_pkg::ibf_ret_t [1:0] ret_o
);
   import ibf_pkg::*;
   ibf_req_t pend_q[$]; // Accepted requests not yet answered
   logic [3:0] tick_q; // Pace pattern, gives prompt and slow spells
   // Accept three of four cycles, answer in bursts with gaps
   always @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tick_q <= 4'h0;
         req_rdy_o <= 1'b0;
         ret_o <= '0;
      end else begin
         tick_q <= tick_q + 4'h1;
         req_rdy_o <= tick_q[1:0] != 2'h3;
         if (req_o.vld && req_rdy_o) pend_q.push_back(req_o);
         for (int l = 0; l < 2; l++) begin
            if (tick_q[2] && pend_q.size() > 0) begin
               ret_o[l].tag <= {1'b1, pend_q[0].tag.buf_sel, pend_q[0].tag.elem};
               ret_o[l].data <= pend_q[0].addr[15:0] ^ 16'h5a3c;
               void'(pend_q.pop_front());
            end else begin
               ret_o[l].tag.vld <= 1'b0; // Idle lane; data toggles, never a stale copy
               ret_o[l].data <= ~ret_o[l].data;
            end
         end
      end
   end
endmodule : ibf_mem_model

/* tb/instruction_buffer_fetch_test.sv */
// Self-checking bench for the instruction buffer fetch block
`timescale 1ns/10ps
module instruction_buffer_fetch_test;
   import ibf_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   ibf_ret_t [1:0] ret_i;
   logic req_rdy_i;
   ibf_req_t req_o;
   logic br_vld_i = 1'b0;
   logic [29:0] br_addr_i = 30'h0;
   logic iss_take_i = 1'b0;
   ibf_iss_t iss_o;
   logic ds_fetch_o;
   logic [7:0] fanout_o;
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   int ds_n = 0; // Deadstart pulses seen
   logic hold = 1'b0; // Keeps the issue side from taking around a branch
   logic [31:0] lfsr_q = 32'h7558;
   logic [29:0] exp_iss[$]; // Word addresses expected at issue
   logic [31:0] exp_req[$]; // Group and word address expected as requests
   always #50 ref_clk_i = ~ref_clk_i;
   ibf_fetch_ctrl dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ret_i(ret_i),
      .req_rdy_i(req_rdy_i), .req_o(req_o), .br_vld_i(br_vld_i), .br_addr_i(br_addr_i),
      .iss_take_i(iss_take_i), .iss_o(iss_o), .ds_fetch_o(ds_fetch_o), .fanout_o(fanout_o));
   ibf_mem_model mem (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_o(req_o),
      .req_rdy_o(req_rdy_i), .ret_o(ret_i));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out();
      if (num_errors == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out
   // One classic cycle; held until ack is sampled, then released
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [31:0] e);
      @(posedge ref_clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hf;
      wb_dat_i <= d;
      do @(posedge ref_clk_i); while (wb_ack_o !== 1'b1);
      if (!we) check(48'(wb_dat_o & m), 48'(e));
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb
   // Branch, note the expected requests and issue words, wait for issue
   task automatic branch(input logic [29:0] a, input int n, input logic miss, input int pf);
      hold = 1'b1;
      repeat (2) @(posedge ref_clk_i);
      exp_iss.delete();
      for (int i = 0; i < n; i++) exp_iss.push_back(a + 30'(i));
      for (int i = 0; i < 32 && miss; i++) begin
         exp_req.push_back({2'(i / 8), a[29:5], 5'(a[4:0] + 5'(i))});
      end
      for (int i = 0; i < pf; i++) begin
         exp_req.push_back({2'(i / 8), a[29:5] + 25'h1, 5'(i)});
      end
      br_vld_i <= 1'b1;
      br_addr_i <= a;
      @(posedge ref_clk_i);
      br_vld_i <= 1'b0;
      hold = 1'b0;
      for (int t = 0; t < 3000 && exp_iss.size() > 0; t++) @(posedge ref_clk_i);
      repeat (60) @(posedge ref_clk_i);
   endtask : branch
   // Watches requests and issue; the oldest note is compared with each result
   always @(posedge ref_clk_i) begin : mon
      logic [29:0] e;
      logic [31:0] r;
      lfsr_q <= lfsr(lfsr_q);
      ds_n += int'(ds_fetch_o);
      if (req_o.vld && req_rdy_i) begin
         r = exp_req.size() > 0 ? exp_req.pop_front() : 'x;
         check(48'({req_o.grp, req_o.addr}), 48'(r));
         check(48'(fanout_o), 48'(8'h01 << req_o.tag.buf_sel));
      end
      if (iss_take_i && iss_o.vld) begin
         e = exp_iss.size() > 0 ? exp_iss.pop_front() : 'x;
         check({2'b0, iss_o.pa, iss_o.word}, {2'b0, e, e[15:0] ^ 16'h5a3c});
      end
      iss_take_i <= !hold && lfsr_q[3] && exp_iss.size() > 0;
   end
   // Cut a hang short
   always @(posedge ref_clk_i) begin
      if (++cycles == 20000) begin
         num_errors++;
         close_out();
      end
   end
   initial begin
      repeat (16) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      wb(1'b0, REG_CTRL, 32'h0, 32'h1, 32'h1);
      wb(1'b0, REG_LIMIT, 32'h0, 32'hffffffff, 32'h3fffffff);
      wb(1'b0, 8'h40, 32'h0, 32'hffffffff, 32'h0);
      wb(1'b1, REG_CTRL, 32'h0, 32'h0, 32'h0);
      wb(1'b0, REG_CTRL, 32'h0, 32'h1, 32'h0);
      wb(1'b1, REG_CTRL, 32'h1, 32'h0, 32'h0);
      branch(30'h205, 40, 1'b1, 32);
      branch(30'h210, 8, 1'b0, 0);
      wb(1'b0, REG_PTR, 32'h0, 32'h3fffffe0, 32'h200);
      wb(1'b1, REG_LIMIT, 32'h7ff, 32'h0, 32'h0);
      wb(1'b0, REG_LIMIT, 32'h0, 32'hffffffff, 32'h7ff);
      // Prefetch is dropped at the limit; running off the end then fetches the next block
      branch(30'h7f8, 8, 1'b1, 32);
      wb(1'b0, REG_STAT, 32'h0, 32'h30, 32'h20);
      wb(1'b1, REG_STAT, 32'h20, 32'h0, 32'h0);
      wb(1'b0, REG_STAT, 32'h0, 32'h20, 32'h0);
      check(48'(ds_n), 48'h1);
      check(48'(exp_req.size()), 48'h0);
      close_out();
   end
endmodule : instruction_buffer_fetch_test
bind ibf_fetch_ctrl ibf_chk chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .req_rdy_i(req_rdy_i), .req_o(req_o),
   .ret_i(ret_i), .br_vld_i(br_vld_i), .iss_take_i(iss_take_i), .iss_o(iss_o),
   .ds_fetch_o(ds_fetch_o), .fanout_o(fanout_o));
